/* tsl_pkg.sv */
// Summary of operation
// - Sixteen touch inputs (seven on small part), each driving the same-numbered output.
// - Internal tick comes from the external timing network, 50 to 100 kHz.
// - An active channel drives toward the output rail, otherwise floats.
// - Momentary mode: an output is active only while its switch is touched.
// - Toggle mode: each qualified touch flips the latched output on or off.
// - In toggle mode a momentary-level pulse on mode select clears every latch.
// - Combination parts keep some channels momentary whatever the mode select.
// - Seven-input combination part: four momentary and three toggle channels.
// - The panel scan clock is generated from the same timing network.
// - A touch gets no response until it has lasted the switch delay.
// - Latch clearing through mode select takes the reset time, typically 100 ms.
// - Mode select is pulled to the momentary level when left open.
`default_nettype none
package tsl_pkg;
    localparam int unsigned RC_MIN_HZ = 50000;
    localparam int unsigned RC_MAX_HZ = 100000;
    localparam int unsigned SW_DELAY_MIN_MS = 65;
    localparam int unsigned SW_DELAY_MAX_MS = 135;
    localparam int unsigned CLR_TYP_MS = 100;
    localparam int unsigned CLR_MAX_MS = 135;
    // Delay in internal ticks at the lower oscillator limit, rounded up
    localparam int unsigned QUAL_TICKS = (SW_DELAY_MIN_MS * RC_MIN_HZ + 999) / 1000;
    localparam int unsigned CLR_TICKS = CLR_TYP_MS * RC_MIN_HZ / 1000;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned NUM_CH_FULL = 16;
    localparam int unsigned NUM_CH_SMALL = 7;
    localparam logic [6:0] COMBO7_FIXED_MASK = 7'h0f;
    // Mode select level that the internal pull gives an open pin
    localparam logic MODE_MOMENTARY = 1'b1;
    typedef enum logic [1:0] {
        TSL_IDLE = 2'b00,
        TSL_QUAL = 2'b01,
        TSL_HELD = 2'b10
    } tsl_state_t;
    typedef struct packed {
        logic tick;
        logic toggle_mode;
        logic clear_all;
    } tsl_ctl_t;
endpackage : tsl_pkg
`default_nettype wire

/* tsl_chan.sv */
`default_nettype none
module tsl_chan
    import tsl_pkg::*;
#(
    parameter logic [CNT_W-1:0] QUAL_CNT = CNT_W'(QUAL_TICKS)
) (
    input wire logic clk,
    input wire logic rst,
    input wire tsl_ctl_t ctl,
    input wire logic touched,
    input wire logic fixed_mom,
    output logic active
);
    tsl_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic latch_r, latch_nxt;
    logic flip;
    logic toggle_eff;

    assign toggle_eff = ctl.toggle_mode & ~fixed_mom;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        flip = 1'b0;
        unique case (state_r)
            TSL_IDLE: begin
                cnt_nxt = '0;
                if (touched) begin
                    state_nxt = TSL_QUAL;
                end
            end
            TSL_QUAL: begin
                if (!touched) begin
                    state_nxt = TSL_IDLE;
                    cnt_nxt = '0;
                end else if (ctl.tick) begin
                    if (cnt_r == QUAL_CNT - 1'b1) begin
                        state_nxt = TSL_HELD;
                        flip = toggle_eff;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            TSL_HELD: begin
                // Must see a release before qualifying again
                if (!touched) begin
                    state_nxt = TSL_IDLE;
                    cnt_nxt = '0;
                end
            end
            default: begin
                state_nxt = TSL_IDLE;
                cnt_nxt = '0;
            end
        endcase
        // A flip in the clearing cycle still counts
        if (flip) begin
            latch_nxt = ~latch_r;
        end else if (ctl.clear_all) begin
            latch_nxt = 1'b0;
        end else begin
            latch_nxt = latch_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= TSL_IDLE;
            cnt_r <= '0;
            latch_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            latch_r <= latch_nxt;
        end
    end

    assign active = toggle_eff ? latch_r : (state_r == TSL_HELD);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_qual_full_count: assert property (
        (state_r == TSL_QUAL && state_nxt == TSL_HELD) |-> (cnt_r == QUAL_CNT - 1'b1 && ctl.tick)
    ) else $error("Touch qualified before full delay");
    a_release_restart: assert property (
        (state_r != TSL_IDLE && !touched) |=> (state_r == TSL_IDLE && cnt_r == '0)
    ) else $error("Release did not restart the count");
    a_mom_follows: assert property (
        (!toggle_eff && active) |-> $past(touched)
    ) else $error("Momentary output active without touch");
    a_toggle_flip: assert property (
        flip |=> (latch_r != $past(latch_r))
    ) else $error("Latch did not flip on qualified touch");
    a_clear_latch: assert property (
        (ctl.clear_all && !flip) |=> !latch_r
    ) else $error("Latch not cleared");
    a_fixed_no_latch: assert property (
        fixed_mom |-> !latch_r
    ) else $error("Fixed momentary channel latched");
    a_one_flip: assert property (
        flip |=> (state_r == TSL_HELD && !flip)
    ) else $error("Second flip without release");
    c_toggle_on: cover property (flip && !latch_r);
    c_toggle_off: cover property (flip && latch_r);
    c_restart: cover property (state_r == TSL_QUAL && !touched && cnt_r != '0);
endmodule : tsl_chan
`default_nettype wire

/* tsl_top.sv */
`default_nettype none
module tsl_top
    import tsl_pkg::*;
#(
    parameter int unsigned NUM_CH = NUM_CH_FULL,
    parameter logic [NUM_CH-1:0] FIXED_MOM_MASK = '0,
    parameter logic [CNT_W-1:0] QUAL_CNT = CNT_W'(QUAL_TICKS),
    parameter logic [CNT_W-1:0] CLR_CNT = CNT_W'(CLR_TICKS)
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Timing network and mode pins
    input wire logic TIMING_NETWORK_INPUT,
    input wire logic MODE_SELECT,
    // Panel side
    input wire logic [NUM_CH-1:0] TOUCH_IN,
    output logic PANEL_SCAN_CLOCK,
    // Open-drain outputs toward the source rail
    output logic [NUM_CH-1:0] CH_OUT_O,
    output logic [NUM_CH-1:0] CH_OUT_OE
);
    // Pin synchronisers
    logic [2:0] tn_sync_r;
    logic [2:0] mode_sync_r;
    logic [NUM_CH-1:0] touch_s1_r, touch_s2_r, touch_s3_r;
    logic tn_stable_r, tn_stable_nxt;
    logic mode_stable_r, mode_stable_nxt;
    logic [NUM_CH-1:0] touch_stable_r, touch_stable_nxt;
    // Timing and clearing
    logic tick_r, tick_nxt;
    logic scan_r, scan_nxt;
    logic [CNT_W-1:0] clr_cnt_r, clr_cnt_nxt;
    logic clear_r, clear_nxt;
    logic toggle_r, toggle_nxt;
    // Channel results
    logic [NUM_CH-1:0] active;
    logic [NUM_CH-1:0] oe_r, oe_nxt;
    logic [NUM_CH-1:0] rail_r, rail_nxt;
    tsl_ctl_t ctl;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tn_sync_r <= '0;
            mode_sync_r <= {3{MODE_MOMENTARY}};
            touch_s1_r <= '0;
            touch_s2_r <= '0;
            touch_s3_r <= '0;
        end else begin
            tn_sync_r <= {tn_sync_r[1:0], TIMING_NETWORK_INPUT};
            mode_sync_r <= {mode_sync_r[1:0], MODE_SELECT};
            touch_s1_r <= TOUCH_IN;
            touch_s2_r <= touch_s1_r;
            touch_s3_r <= touch_s2_r;
        end
    end

    // Second and third stages must agree before a level is believed
    always_comb begin
        tn_stable_nxt = (tn_sync_r[1] == tn_sync_r[2]) ? tn_sync_r[2] : tn_stable_r;
        mode_stable_nxt = (mode_sync_r[1] == mode_sync_r[2]) ? mode_sync_r[2] : mode_stable_r;
        for (int i = 0; i < NUM_CH; i++) begin
            touch_stable_nxt[i] = (touch_s2_r[i] == touch_s3_r[i]) ?
                touch_s3_r[i] : touch_stable_r[i];
        end
    end

    // One tick per rising edge of the oscillator network
    always_comb begin
        tick_nxt = tn_stable_nxt & ~tn_stable_r;
        scan_nxt = scan_r ^ tick_r;
    end

    // Clear needs the momentary level held for the reset time; shorter
    // glitches only show momentary behaviour and leave the latches alone.
    always_comb begin
        toggle_nxt = (mode_stable_r != MODE_MOMENTARY);
        clr_cnt_nxt = clr_cnt_r;
        clear_nxt = clear_r;
        if (mode_stable_r != MODE_MOMENTARY) begin
            clr_cnt_nxt = '0;
            clear_nxt = 1'b0;
        end else if (tick_r && clr_cnt_r != CLR_CNT) begin
            clr_cnt_nxt = clr_cnt_r + 1'b1;
            clear_nxt = (clr_cnt_r == CLR_CNT - 1'b1);
        end
    end

    always_comb begin
        oe_nxt = active;
        rail_nxt = '1;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tn_stable_r <= 1'b0;
            mode_stable_r <= MODE_MOMENTARY;
            touch_stable_r <= '0;
            tick_r <= 1'b0;
            scan_r <= 1'b0;
            clr_cnt_r <= '0;
            clear_r <= 1'b0;
            toggle_r <= 1'b0;
            oe_r <= '0;
            rail_r <= '1;
        end else begin
            tn_stable_r <= tn_stable_nxt;
            mode_stable_r <= mode_stable_nxt;
            touch_stable_r <= touch_stable_nxt;
            tick_r <= tick_nxt;
            scan_r <= scan_nxt;
            clr_cnt_r <= clr_cnt_nxt;
            clear_r <= clear_nxt;
            toggle_r <= toggle_nxt;
            oe_r <= oe_nxt;
            rail_r <= rail_nxt;
        end
    end

    assign ctl = '{tick: tick_r, toggle_mode: toggle_r, clear_all: clear_r};

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            tsl_chan #(
                .QUAL_CNT(QUAL_CNT)
            ) u_chan (
                .clk(REF_CLK),
                .rst(RST),
                .ctl(ctl),
                .touched(touch_stable_r[g]),
                .fixed_mom(FIXED_MOM_MASK[g]),
                .active(active[g])
            );

            // Ticks seen while the input is believed touched, kept apart from
            // the channel's own counter so the delay check stays independent
            logic [CNT_W-1:0] seen_r, seen_nxt;

            always_comb begin
                seen_nxt = seen_r;
                if (!touch_stable_r[g]) begin
                    seen_nxt = '0;
                end else if (tick_r && seen_r != QUAL_CNT) begin
                    seen_nxt = seen_r + 1'b1;
                end
            end

            always_ff @(posedge REF_CLK) begin
                if (RST) begin
                    seen_r <= '0;
                end else begin
                    seen_r <= seen_nxt;
                end
            end

            a_full_delay: assert property (
                @(posedge REF_CLK) disable iff (RST)
                ($rose(active[g]) && $stable(toggle_r)) |-> (seen_r == QUAL_CNT)
            ) else $error("Output rose before the full switch delay");
        end
    endgenerate

    assign PANEL_SCAN_CLOCK = scan_r;
    // Output data is the rail itself; only the enable switches
    assign CH_OUT_O = rail_r;
    assign CH_OUT_OE = oe_r;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    a_tick_on_edge: assert property (
        tick_r |-> ($past(tn_stable_r) == 1'b0 && $past(tn_stable_nxt) == 1'b1)
    ) else $error("Tick without oscillator edge");
    a_scan_follows: assert property (
        (PANEL_SCAN_CLOCK != $past(PANEL_SCAN_CLOCK)) == $past(tick_r, 1)
    ) else $error("Scan clock not tied to ticks");
    a_out_map: assert property (
        CH_OUT_OE == $past(active)
    ) else $error("Output enable does not follow its channel");
    a_out_rail: assert property (
        CH_OUT_O == {NUM_CH{1'b1}}
    ) else $error("Output data not at rail level");
    a_clear_count: assert property (
        (tick_r && clr_cnt_r == CLR_CNT - 1'b1 && mode_stable_r == MODE_MOMENTARY)
            |=> clear_r
    ) else $error("Clear not raised after reset time");
    a_clear_cause: assert property (
        clear_r |-> (mode_stable_r == MODE_MOMENTARY || $past(mode_stable_r) == MODE_MOMENTARY)
    ) else $error("Clear without momentary level");
    a_mode_open: assert property (
        (mode_stable_r == MODE_MOMENTARY) |=> !toggle_r
    ) else $error("Momentary level did not select momentary mode");
    a_tick_single: assert property (
        tick_r |=> !tick_r
    ) else $error("Tick lasted more than one cycle");
    a_toggle_select: assert property (
        (mode_stable_r != MODE_MOMENTARY) |=> toggle_r
    ) else $error("Toggle level did not select toggle mode");
    a_clear_hold: assert property (
        (clear_r && mode_stable_r == MODE_MOMENTARY) |=> clear_r
    ) else $error("Clear dropped while momentary level held");
    a_clear_drop: assert property (
        (mode_stable_r != MODE_MOMENTARY) |=> !clear_r
    ) else $error("Clear kept after toggle level returned");
    a_clear_late: assert property (
        $rose(clear_r) |-> (clr_cnt_r == CLR_CNT)
    ) else $error("Clear raised before the reset time");
    // Slow pin edges may ring; a level is trusted only once two stages agree
    a_mode_sync: assert property (
        $changed(mode_stable_r) |-> $past(mode_sync_r[1] == mode_sync_r[2])
    ) else $error("Mode level believed before two stages agreed");
    a_touch_sync: assert property (
        ((touch_stable_r ^ $past(touch_stable_r)) & $past(touch_s2_r ^ touch_s3_r)) == '0
    ) else $error("Touch level believed before two stages agreed");
    a_mom_idle: assert property (
        ((touch_stable_r == '0) ##1 !toggle_r) |=> (CH_OUT_OE == '0)
    ) else $error("Momentary output active with nothing touched");
    a_fixed_idle: assert property (
        (((touch_stable_r & FIXED_MOM_MASK) == '0) ##1 1'b1)
            |=> ((CH_OUT_OE & FIXED_MOM_MASK) == '0)
    ) else $error("Fixed momentary output active without touch");
    c_clear: cover property ($rose(clear_r));
    c_any_out: cover property (|CH_OUT_OE);
endmodule : tsl_top
`default_nettype wire

/* tsl_panel_model.sv */
`default_nettype none
module tsl_panel_model
    import tsl_pkg::*;
#(
    parameter int unsigned N = 7,
    parameter int unsigned HALF = 200
) (
    // Clock
    input wire logic clk,
    // Bench requests
    input wire logic [N-1:0] touch_req,
    input wire logic mode_drive,
    input wire logic mode_val,
    // Device pins
    input wire logic [N-1:0] ch_o,
    input wire logic [N-1:0] ch_oe,
    output logic osc,
    output logic [N-1:0] touch_in,
    output logic mode_sel,
    output logic [N-1:0] load_level
);
    timeunit 1ns;
    timeprecision 1ps;
    initial osc = 1'b0;
    // RC network runs free at its upper limit to keep the run short
    always begin
        repeat (HALF) @(negedge clk);
        osc = ~osc;
    end
    assign touch_in = touch_req;
    // Open pin falls back to the internal pull level
    assign mode_sel = mode_drive ? mode_val : MODE_MOMENTARY;
    // Load resistor pulls to the far rail while a channel floats
    assign load_level = ch_oe & ch_o;
endmodule : tsl_panel_model
`default_nettype wire

/* tsl_top_bench.sv */
`default_nettype none
module tsl_top_bench
    import tsl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst;
    logic [6:0] touch_req;
    logic mode_drive;
    logic mode_val;
    logic osc;
    logic mode_sel;
    logic scan;
    logic [6:0] touch_in;
    logic [6:0] ch_o;
    logic [6:0] ch_oe;
    logic [6:0] lvl;
    int fails = 0;
    int checks = 0;
    always #12.5 clk = ~clk;
    tsl_top #(.NUM_CH(7), .FIXED_MOM_MASK(COMBO7_FIXED_MASK), .QUAL_CNT(16'h0004),
        .CLR_CNT(16'h0006)) tsl_top_inst (.REF_CLK(clk), .RST(rst),
        .TIMING_NETWORK_INPUT(osc), .MODE_SELECT(mode_sel), .TOUCH_IN(touch_in),
        .PANEL_SCAN_CLOCK(scan), .CH_OUT_O(ch_o), .CH_OUT_OE(ch_oe));
    tsl_panel_model #(.N(7), .HALF(200)) tsl_panel_model_inst (.clk(clk),
        .touch_req(touch_req), .mode_drive(mode_drive), .mode_val(mode_val),
        .ch_o(ch_o), .ch_oe(ch_oe), .osc(osc), .touch_in(touch_in),
        .mode_sel(mode_sel), .load_level(lvl));
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // Lands on the falling edge just after an oscillator rise
    task automatic sync_osc;
        int i;
        logic prev;
        prev = 1'b1;
        for (i = 0; i < 1000; i++) begin
            @(posedge clk);
            if (prev === 1'b0 && osc === 1'b1) break;
            prev = osc;
        end
        if (i == 1000) begin
            fails++;
            $display("[FAIL] osc rise expected 1 seen 0");
            end_of_test();
        end else begin
            @(negedge clk);
        end
    endtask : sync_osc
    // Touch mid-period: fourth tick lands near 1405 cycles later
    task automatic qual(input logic [6:0] m, input logic [6:0] pre, input logic [6:0] post);
        sync_osc();
        cyc(200);
        touch_req = m;
        cyc(1300);
        chk("early", pre, lvl);
        cyc(200);
        chk("qualified", post, lvl);
    endtask : qual
    task automatic rel(input logic [6:0] exp);
        touch_req = '0;
        cyc(20);
        chk("released", exp, lvl);
    endtask : rel
    task automatic t_scan;
        logic [6:0] n;
        logic p;
        n = '0;
        sync_osc();
        p = scan;
        repeat (1600) begin
            @(negedge clk);
            n = n + 7'(scan != p);
            p = scan;
        end
        chk("scan flips", 7'h04, n);
        $display("scan test done");
    endtask : t_scan
    task automatic t_momentary;
        touch_req = 7'h20;
        cyc(1000);
        chk("short touch", 7'h00, lvl);
        touch_req = '0;
        cyc(400);
        qual(7'h20, 7'h00, 7'h20);
        rel(7'h00);
        $display("momentary test done");
    endtask : t_momentary
    task automatic t_toggle;
        mode_drive = 1'b1;
        mode_val = 1'b0;
        cyc(50);
        qual(7'h1f, 7'h00, 7'h1f);
        rel(7'h10);
        qual(7'h60, 7'h10, 7'h70);
        cyc(3200);
        chk("held", 7'h70, lvl);
        rel(7'h70);
        qual(7'h10, 7'h70, 7'h60);
        rel(7'h60);
        qual(7'h10, 7'h60, 7'h70);
        rel(7'h70);
        $display("toggle test done");
    endtask : t_toggle
    task automatic t_clear;
        mode_val = 1'b1;
        cyc(800);
        chk("mom level", 7'h00, lvl);
        mode_val = 1'b0;
        cyc(20);
        chk("short pulse", 7'h70, lvl);
        mode_val = 1'b1;
        cyc(3600);
        mode_val = 1'b0;
        cyc(20);
        chk("cleared", 7'h00, lvl);
        mode_drive = 1'b0;
        $display("clear test done");
    endtask : t_clear
    initial begin
        rst = 1'b1;
        touch_req = '0;
        mode_drive = 1'b0;
        mode_val = 1'b0;
        cyc(20);
        rst = 1'b0;
        cyc(4);
        chk("after reset", 7'h00, ch_oe);
        t_scan();
        t_momentary();
        t_toggle();
        t_clear();
        end_of_test();
    end
endmodule : tsl_top_bench
`default_nettype wire
